/* rtl/qw_flash_seq.v */
`timescale 1ns/1ps
`include "qw_defs.vh"

// Summary of operation
// - word read: mode byte, then two dummies
// - read from any byte, address increments
// - word read opcode taken only while quad enable set; continuous-mode frames skip the check
// - mode nibble A: next frame starts at address
// - other mode value: next frame needs opcode
// - mode reset command clears continuous mode
// - program data wraps inside the page
// - over 256 bytes: keep last 256
// - short program leaves other bytes unchanged
// - program ends on byte boundary, else dropped
// - program starts timed cycle, busy shown
// - latch cleared during cycle, status readable
// - protected page program not executed
// - sector wipe opcode, any address in sector
// - erase ends right after address, else dropped
// - sector wipe runs timed cycle, busy shown
// - protected sector wipe ignored
// - block wipe opcode, timed cycle
// - protected block wipe not executed
// - sample on rising, drive on falling
// - quad phases carry four bits per clock
module qw_flash_seq #(
    parameter [31:0] PP_CYCLES = `QW_TPP_US * `QW_CLK_MHZ,
    parameter [31:0] SE_CYCLES = `QW_TSE_MS * 1000 * `QW_CLK_MHZ,
    parameter [31:0] BE_CYCLES = `QW_TBE_MS * 1000 * `QW_CLK_MHZ
) (
    // clock and reset
    input  wire        clk_in,
    input  wire        rst_n_in,
    // serial pins
    input  wire        cs_n_in,
    input  wire        sclk_in,
    input  wire [3:0]  io_in,
    output wire [3:0]  io_out,
    output wire [3:0]  io_oe_out,
    // configuration
    input  wire        quad_enable_in,
    // protection lookup
    output wire [23:0] prot_addr_out,
    output wire [1:0]  prot_kind_out,
    input  wire        prot_hit_in,
    // status
    output wire        write_in_progress_out,
    output wire        write_enable_latch_out,
    output wire        cont_mode_out,
    // array read port
    output wire [23:0] mem_rd_addr_out,
    output wire        mem_rd_en_out,
    input  wire [7:0]  mem_rd_data_in,
    // array modify port
    output wire        op_start_out,
    output wire [1:0]  op_kind_out,
    output wire [23:0] op_addr_out,
    input  wire [7:0]  buf_rd_addr_in,
    output wire [7:0]  buf_rd_data_out,
    output wire        buf_rd_mask_out
);

    // frame states
    localparam [3:0] ST_CMD   = 4'h0;  // shifting opcode
    localparam [3:0] ST_ADDR  = 4'h1;  // shifting address
    localparam [3:0] ST_MODE  = 4'h2;  // continuous mode byte
    localparam [3:0] ST_DUMMY = 4'h3;  // dummy clocks
    localparam [3:0] ST_RDATA = 4'h4;  // quad read data out
    localparam [3:0] ST_PDATA = 4'h5;  // program data in
    localparam [3:0] ST_EWAIT = 4'h6;  // erase waits for cs rise
    localparam [3:0] ST_STAT  = 4'h7;  // status byte out
    localparam [3:0] ST_DONE  = 4'h8;  // one-byte command taken
    localparam [3:0] ST_IGN   = 4'h9;  // rest of frame ignored

    // synchronised pins
    wire [5:0] pin_s;
    wire       cs_s   = pin_s[5];
    wire       sclk_s = pin_s[4];
    wire [3:0] io_s   = pin_s[3:0];

    reg        cs_d_reg;     // previous cs level for edges
    reg        sclk_d_reg;   // previous sclk level for edges
    reg [3:0]  state_reg;
    reg [4:0]  cnt_reg;      // clocks within the phase
    reg [7:0]  cmd_reg;      // opcode of the frame
    reg [23:0] addr_reg;     // address being shifted / read pointer
    reg [7:0]  byte_reg;     // program byte or mode byte shifter
    reg        quad_reg;     // address phase is four bits wide
    reg        cont_reg;     // continuous read mode held
    reg        nib_reg;      // next fall drives low nibble
    reg [7:0]  rbyte_reg;    // byte being sent on a read
    reg        rd_pend_reg;  // array read answer due this cycle
    reg        rd_en_reg;
    reg [7:0]  poff_reg;     // program write offset in page
    reg        pany_reg;     // at least one whole byte received
    reg [2:0]  sbit_reg;     // status bit pointer
    reg [3:0]  io_reg;
    reg        wel_reg;
    reg [31:0] busy_reg;     // remaining cycles of timed operation
    reg        start_reg;
    reg [1:0]  kind_reg;
    reg [23:0] op_addr_reg;
    reg        buf_clr_reg;
    reg        buf_we_reg;
    reg [7:0]  buf_wa_reg;
    reg [7:0]  buf_wd_reg;

    wire busy      = (busy_reg != 32'h0);
    wire cs_fall   = ~cs_s & cs_d_reg;
    wire cs_rise   = cs_s & ~cs_d_reg;
    // clock edges only count while selected
    wire sclk_rise = sclk_s & ~sclk_d_reg & ~cs_s;
    wire sclk_fall = ~sclk_s & sclk_d_reg & ~cs_s;
    wire [7:0] op_now = {cmd_reg[6:0], io_s[0]};
    wire [7:0] sbyte  = {6'h00, wel_reg, busy};
    wire [1:0] ekind  = (cmd_reg == `QW_OP_SECT_WIPE) ?
                        `QW_KIND_SECT : `QW_KIND_BLK;
    wire [1:0] pkind  = (cmd_reg == `QW_OP_PROGRAM) ?
                        `QW_KIND_PAGE : ekind;

    // pins pass two flops before anything reads them
    qw_sync #(
        .W(6)
    ) u_sync (
        .clk_in   (clk_in),
        .rst_n_in (rst_n_in),
        .d_in     ({cs_n_in, sclk_in, io_in}),
        .q_out    (pin_s)
    );

    // program data staging, drained by the array during the cycle
    qw_page_buf #(
        .AW(8),
        .DW(8)
    ) u_buf (
        .clk_in      (clk_in),
        .rst_n_in    (rst_n_in),
        .clr_in      (buf_clr_reg),
        .wr_en_in    (buf_we_reg),
        .wr_addr_in  (buf_wa_reg),
        .wr_data_in  (buf_wd_reg),
        .rd_addr_in  (buf_rd_addr_in),
        .rd_data_out (buf_rd_data_out),
        .rd_mask_out (buf_rd_mask_out)
    );

    // edge history of the synchronised pins
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cs_d_reg   <= 1'b1;
            sclk_d_reg <= 1'b1;  // same as sync reset, no false edge
        end else begin
            cs_d_reg   <= cs_s;
            sclk_d_reg <= sclk_s;
        end
    end

    // frame decoder: rising edges sample, falling edges drive
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state_reg   <= ST_CMD;
            cnt_reg     <= 5'h00;
            cmd_reg     <= 8'h00;
            addr_reg    <= 24'h000000;
            byte_reg    <= 8'h00;
            quad_reg    <= 1'b0;
            cont_reg    <= 1'b0;
            nib_reg     <= 1'b0;
            rbyte_reg   <= 8'h00;
            rd_pend_reg <= 1'b0;
            rd_en_reg   <= 1'b0;
            poff_reg    <= 8'h00;
            pany_reg    <= 1'b0;
            sbit_reg    <= 3'h7;
            io_reg      <= 4'h0;
            wel_reg     <= 1'b0;
            busy_reg    <= 32'h0;
            start_reg   <= 1'b0;
            kind_reg    <= `QW_KIND_PAGE;
            op_addr_reg <= 24'h000000;
            buf_clr_reg <= 1'b0;
            buf_we_reg  <= 1'b0;
            buf_wa_reg  <= 8'h00;
            buf_wd_reg  <= 8'h00;
        end else begin
            // one-cycle strobes default low
            start_reg   <= 1'b0;
            rd_en_reg   <= 1'b0;
            buf_clr_reg <= 1'b0;
            buf_we_reg  <= 1'b0;
            rd_pend_reg <= rd_en_reg;
            if (rd_pend_reg) begin
                rbyte_reg <= mem_rd_data_in;
            end
            if (busy) begin
                busy_reg <= busy_reg - 32'h1;
            end

            if (cs_fall) begin
                if (cont_reg) begin
                    state_reg <= ST_ADDR;
                    cmd_reg   <= `QW_OP_WORD_READ;
                    quad_reg  <= 1'b1;
                end else begin
                    state_reg <= ST_CMD;
                    cmd_reg   <= 8'h00;
                    quad_reg  <= 1'b0;
                end
                cnt_reg  <= 5'h00;
                nib_reg  <= 1'b0;
                pany_reg <= 1'b0;
                sbit_reg <= 3'h7;
            end else if (cs_rise) begin
                state_reg <= ST_CMD;
                case (state_reg)
                    ST_DONE: begin
                        if (cmd_reg == `QW_OP_WR_ENABLE) begin
                            wel_reg <= 1'b1;
                        end
                    end
                    ST_PDATA: begin
                        // only whole bytes end a program
                        if (cnt_reg[2:0] == 3'h0 && pany_reg &&
                            wel_reg && !prot_hit_in) begin
                            busy_reg    <= PP_CYCLES;
                            start_reg   <= 1'b1;
                            kind_reg    <= `QW_KIND_PAGE;
                            op_addr_reg <= {addr_reg[23:8], 8'h00};
                            wel_reg     <= 1'b0;
                        end
                    end
                    ST_EWAIT: begin
                        if (wel_reg && !prot_hit_in) begin
                            busy_reg    <= (ekind == `QW_KIND_SECT) ?
                                           SE_CYCLES : BE_CYCLES;
                            start_reg   <= 1'b1;
                            kind_reg    <= ekind;
                            op_addr_reg <= addr_reg;
                            wel_reg     <= 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end else if (sclk_rise) begin
                cnt_reg <= cnt_reg + 5'h01;
                case (state_reg)
                    ST_CMD: begin
                        cmd_reg <= op_now;
                        if (cnt_reg == `QW_CMD_CLKS) begin
                            cnt_reg <= 5'h00;
                            if (busy && op_now != `QW_OP_RD_STATUS) begin
                                state_reg <= ST_IGN;
                            end else begin
                                case (op_now)
                                    `QW_OP_WORD_READ: begin
                                        quad_reg  <= 1'b1;
                                        state_reg <= quad_enable_in ?
                                                     ST_ADDR : ST_IGN;
                                    end
                                    `QW_OP_PROGRAM: begin
                                        buf_clr_reg <= 1'b1;
                                        state_reg   <= ST_ADDR;
                                    end
                                    `QW_OP_SECT_WIPE: state_reg <= ST_ADDR;
                                    `QW_OP_BLK_WIPE:  state_reg <= ST_ADDR;
                                    `QW_OP_WR_ENABLE: state_reg <= ST_DONE;
                                    `QW_OP_RD_STATUS: state_reg <= ST_STAT;
                                    `QW_OP_MODE_RESET: begin
                                        cont_reg  <= 1'b0;
                                        state_reg <= ST_IGN;
                                    end
                                    default: state_reg <= ST_IGN;
                                endcase
                            end
                        end
                    end
                    ST_ADDR: begin
                        // quad address four bits a clock
                        if (quad_reg) begin
                            addr_reg <= {addr_reg[19:0], io_s};
                        end else begin
                            addr_reg <= {addr_reg[22:0], io_s[0]};
                        end
                        if (quad_reg && cnt_reg == `QW_ADDR_QD_CLKS) begin
                            cnt_reg   <= 5'h00;
                            state_reg <= ST_MODE;
                        end else if (!quad_reg &&
                                     cnt_reg == `QW_ADDR_SER_CLKS) begin
                            cnt_reg   <= 5'h00;
                            poff_reg  <= {addr_reg[6:0], io_s[0]};
                            state_reg <= (cmd_reg == `QW_OP_PROGRAM) ?
                                         ST_PDATA : ST_EWAIT;
                        end
                    end
                    ST_MODE: begin
                        byte_reg <= {byte_reg[3:0], io_s};
                        if (cnt_reg == `QW_MODE_CLKS) begin
                            cnt_reg <= 5'h00;
                            cont_reg  <= (byte_reg[3:0] == `QW_MODE_KEEP);
                            state_reg <= ST_DUMMY;
                        end
                    end
                    ST_DUMMY: begin
                        if (cnt_reg == `QW_DUMMY_CLKS) begin
                            cnt_reg   <= 5'h00;
                            rd_en_reg <= 1'b1;
                            state_reg <= ST_RDATA;
                        end
                    end
                    ST_PDATA: begin
                        byte_reg <= {byte_reg[6:0], io_s[0]};
                        if (cnt_reg[2:0] == 3'h7) begin
                            buf_we_reg <= 1'b1;
                            buf_wa_reg <= poff_reg;
                            buf_wd_reg <= {byte_reg[6:0], io_s[0]};
                            poff_reg   <= poff_reg + 8'h01;
                            pany_reg   <= 1'b1;
                        end
                    end
                    ST_EWAIT: begin
                        state_reg <= ST_IGN;
                    end
                    ST_DONE: begin
                        state_reg <= ST_IGN;
                    end
                    default: begin
                        cnt_reg <= 5'h00;
                    end
                endcase
            end else if (sclk_fall) begin
                if (state_reg == ST_RDATA) begin
                    if (!nib_reg) begin
                        io_reg  <= rbyte_reg[7:4];
                        nib_reg <= 1'b1;
                    end else begin
                        io_reg    <= rbyte_reg[3:0];
                        nib_reg   <= 1'b0;
                        addr_reg  <= addr_reg + 24'h000001;
                        rd_en_reg <= 1'b1;
                    end
                end else if (state_reg == ST_STAT) begin
                    io_reg   <= {2'b00, sbyte[sbit_reg], 1'b0};
                    sbit_reg <= sbit_reg - 3'h1;
                end
            end
        end
    end

    // the read pointer is the fetch address; it steps to the next byte as the low nibble goes out
    assign mem_rd_addr_out = addr_reg;
    assign mem_rd_en_out   = rd_en_reg;

    // drivers enabled only in the output phases
    assign io_oe_out = (state_reg == ST_RDATA) ? 4'hf :
                       (state_reg == ST_STAT)  ? 4'h2 : 4'h0;
    assign io_out    = io_reg;

    // protection query follows the latched address
    assign prot_addr_out = addr_reg;
    assign prot_kind_out = pkind;

    // status and array control
    assign write_in_progress_out  = busy;
    assign write_enable_latch_out = wel_reg;
    assign cont_mode_out          = cont_reg;
    assign op_start_out           = start_reg;
    assign op_kind_out            = kind_reg;
    assign op_addr_out            = op_addr_reg;

endmodule // qw_flash_seq

/* rtl/qw_defs.vh */
`ifndef QW_DEFS_VH
`define QW_DEFS_VH

// opcodes
`define QW_OP_WORD_READ  8'he7
`define QW_OP_PROGRAM    8'h02
`define QW_OP_SECT_WIPE  8'h20
`define QW_OP_BLK_WIPE   8'h52
`define QW_OP_WR_ENABLE  8'h06
`define QW_OP_RD_STATUS  8'h05
`define QW_OP_MODE_RESET 8'hff

// continuous mode marker in the upper nibble of the mode byte
`define QW_MODE_KEEP     4'ha

// phase lengths in serial clocks, less one (count of the last clock)
`define QW_CMD_CLKS      5'h07
`define QW_ADDR_SER_CLKS 5'h17
`define QW_ADDR_QD_CLKS  5'h05
`define QW_MODE_CLKS     5'h01
`define QW_DUMMY_CLKS    5'h01

// self-timed operation kinds
`define QW_KIND_PAGE     2'h0
`define QW_KIND_SECT     2'h1
`define QW_KIND_BLK      2'h2

// timing, each figure in its own unit, and the clock rate
`define QW_CLK_MHZ       50
`define QW_TPP_US        1000
`define QW_TSE_MS        60
`define QW_TBE_MS        120

`endif

/* rtl/qw_sync.v */
`timescale 1ns/1ps

// two-stage synchroniser for a bundle of unrelated level inputs
module qw_sync #(
    parameter W = 6
) (
    // clock and reset
    input  wire         clk_in,
    input  wire         rst_n_in,
    // async side
    input  wire [W-1:0] d_in,
    // synchronised side
    output wire [W-1:0] q_out
);

    reg [W-1:0] meta_reg;  // first stage, read only by stage two
    reg [W-1:0] sync_reg;  // second stage, safe to use

    // plain double flop; bits may resolve on different cycles
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            meta_reg <= {W{1'b1}};
            sync_reg <= {W{1'b1}};
        end else begin
            meta_reg <= d_in;
            sync_reg <= meta_reg;
        end
    end

    assign q_out = sync_reg;

endmodule // qw_sync

/* rtl/qw_page_buf.v */
`timescale 1ns/1ps

// page buffer with one written-flag per byte, registered read port
module qw_page_buf #(
    parameter AW = 8,
    parameter DW = 8
) (
    // clock and reset
    input  wire          clk_in,
    input  wire          rst_n_in,
    // fill side
    input  wire          clr_in,
    input  wire          wr_en_in,
    input  wire [AW-1:0] wr_addr_in,
    input  wire [DW-1:0] wr_data_in,
    // drain side
    input  wire [AW-1:0] rd_addr_in,
    output wire [DW-1:0] rd_data_out,
    output wire          rd_mask_out
);

    localparam DEPTH = 1 << AW;

    reg [DW-1:0]    mem_reg [0:DEPTH-1];  // byte storage, no reset
    reg [DEPTH-1:0] mask_reg;             // byte was sent this frame
    reg [DW-1:0]    rd_data_reg;
    reg             rd_mask_reg;

    // data store; a later byte to the same offset simply replaces it
    always @(posedge clk_in) begin
        if (wr_en_in) begin
            mem_reg[wr_addr_in] <= wr_data_in;
        end
    end

    // flags cleared per frame so untouched bytes stay unchanged
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            mask_reg <= {DEPTH{1'b0}};
        end else begin
            // a byte landing with the clear still counts: set wins
            if (clr_in) begin
                mask_reg <= {DEPTH{1'b0}};
            end
            if (wr_en_in) begin
                mask_reg[wr_addr_in] <= 1'b1;
            end
        end
    end

    // registered read for the array side
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            rd_data_reg <= {DW{1'b0}};
            rd_mask_reg <= 1'b0;
        end else begin
            rd_data_reg <= mem_reg[rd_addr_in];
            rd_mask_reg <= mask_reg[rd_addr_in];
        end
    end

    assign rd_data_out = rd_data_reg;
    assign rd_mask_out = rd_mask_reg;

endmodule // qw_page_buf

/* verification/qw_flash_seq_assertions.sv */
`timescale 1ns/1ps

// watches the modify handshake and the pin enables of the sequencer
module qw_flash_seq_chk (
    // clock and reset
    input wire        clk_in,
    input wire        rst_n_in,
    // pins and configuration
    input wire        cs_n_in,
    input wire [3:0]  io_oe_out,
    input wire        quad_enable_in,
    input wire        prot_hit_in,
    // status and array side
    input wire        write_in_progress_out,
    input wire        write_enable_latch_out,
    input wire        op_start_out,
    input wire [1:0]  op_kind_out,
    input wire [23:0] op_addr_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    a_start_pulse: assert property (op_start_out |=> !op_start_out)
        else $error("start pulse too long");
    a_start_busy: assert property (
        op_start_out |-> ##[0:2] write_in_progress_out)
        else $error("busy flag not raised");
    a_latch_drop: assert property (
        op_start_out |-> ##[0:2] !write_enable_latch_out)
        else $error("latch kept through cycle");
    a_needs_latch: assert property (
        op_start_out |-> $past(write_enable_latch_out))
        else $error("start without latch");
    a_prot_block: assert property (
        op_start_out |-> !$past(prot_hit_in))
        else $error("protected target started");
    a_page_align: assert property (
        $fell(op_start_out) && op_kind_out == 2'h0
        |-> op_addr_out[7:0] == 8'h00)
        else $error("page address not aligned");
    a_oe_idle: assert property (cs_n_in [*8] |-> io_oe_out == 4'h0)
        else $error("pins driven while deselected");
    a_quad_gate: assert property (
        $rose(io_oe_out == 4'hf) |-> quad_enable_in)
        else $error("quad drive without enable");
endmodule // qw_flash_seq_chk

bind qw_flash_seq qw_flash_seq_chk chk (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in),
    .io_oe_out(io_oe_out), .quad_enable_in(quad_enable_in),
    .prot_hit_in(prot_hit_in), .write_in_progress_out(write_in_progress_out),
    .write_enable_latch_out(write_enable_latch_out),
    .op_start_out(op_start_out), .op_kind_out(op_kind_out),
    .op_addr_out(op_addr_out));

/* verification/qw_host_model.sv */
`timescale 1ns/1ps

// host controller: mode-0 link master, clock parked low between frames
module qw_host_model (
    // clock
    input  wire       clk_in,
    // link pins
    output reg        cs_n_out,
    output reg        sclk_out,
    output reg  [3:0] io_out,
    output reg  [3:0] io_oe_out,
    input  wire [3:0] io_in
);
    initial begin
        cs_n_out  = 1'b1;
        sclk_out  = 1'b0;
        io_out    = 4'h0;
        io_oe_out = 4'h0;
    end
    // one clock, sampled late so the fall lag is covered
    // released lines flip so stale data never passes for valid
    task clk1(input [3:0] d, input [3:0] oe, output [3:0] q);
        begin
            io_out    = (d & oe) | (~io_out & ~oe);
            io_oe_out = oe;
            repeat (4) @(negedge clk_in);
            sclk_out = 1'b1;
            repeat (4) @(negedge clk_in);
            q        = io_in;
            sclk_out = 1'b0;
        end
    endtask
    task ser(input [7:0] b);
        integer k;
        reg [3:0] q;
        begin
            for (k = 7; k >= 0; k = k - 1)
                clk1({3'h0, b[k]}, 4'h1, q);
        end
    endtask
    task frame_on;
        begin
            cs_n_out = 1'b0;
        end
    endtask
    task frame_off;
        begin
            repeat (2) @(negedge clk_in);
            cs_n_out  = 1'b1;
            io_oe_out = 4'h0;
            repeat (12) @(negedge clk_in);
        end
    endtask
endmodule // qw_host_model

/* verification/tb_qw_flash_seq.sv */
`timescale 1ns/1ps

module tb_qw_flash_seq;
    reg         clk_in = 1'b0;
    reg         rst_n_in = 1'b0;
    reg         qe = 1'b1;
    reg         prot = 1'b0;
    reg  [7:0]  mem_q = 8'h00;
    reg  [7:0]  baddr = 8'h00;
    wire        cs_n, sclk, write_in_progress, write_enable_latch, cont, rd_en, start, bmask;
    wire [3:0]  h_io, h_oe, d_io, d_oe, pin;
    wire [23:0] rd_addr, op_addr, pa;
    wire [1:0]  kind, pk;
    wire [7:0]  bdata;
    integer     n_fail = 0;
    integer     check_count = 0;
    integer     starts = 0;
    integer     wip_len = 0;
    integer     j;
    reg  [3:0]  q, q2;
    reg  [7:0]  bt;

    // device wins where it drives, the host value otherwise
    assign pin = (d_oe & d_io) | (~d_oe & h_io);
    always #10 clk_in = ~clk_in;
    // array stand-in: data one clock after the read strobe
    always @(posedge clk_in) begin
        if (rd_en) mem_q <= rd_addr[7:0] ^ 8'ha5;
        if (start) starts <= starts + 1;
        wip_len <= start ? 0 : wip_len + write_in_progress;
        if (|(h_oe & d_oe)) check(h_oe & d_oe, 0);
    end

    qw_host_model host (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk),
        .io_out(h_io), .io_oe_out(h_oe), .io_in(pin));
    qw_flash_seq #(.PP_CYCLES(40), .SE_CYCLES(400), .BE_CYCLES(80)) dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n),
        .sclk_in(sclk), .io_in(pin), .io_out(d_io), .io_oe_out(d_oe),
        .quad_enable_in(qe), .prot_addr_out(pa), .prot_kind_out(pk),
        .prot_hit_in(prot), .write_in_progress_out(write_in_progress),
        .write_enable_latch_out(write_enable_latch), .cont_mode_out(cont),
        .mem_rd_addr_out(rd_addr), .mem_rd_en_out(rd_en),
        .mem_rd_data_in(mem_q), .op_start_out(start), .op_kind_out(kind),
        .op_addr_out(op_addr), .buf_rd_addr_in(baddr),
        .buf_rd_data_out(bdata), .buf_rd_mask_out(bmask));

    task check(input [31:0] seen, input [31:0] exp);
        begin
            check_count = check_count + 1;
            if (seen !== exp) begin
                n_fail = n_fail + 1;
                $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
            end
        end
    endtask
    task complete_run;
        begin
            if (n_fail == 0 && check_count > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task wr(input [7:0] op, input [23:0] a);
        begin
            host.frame_on;
            host.ser(op);
            host.ser(a[23:16]);
            host.ser(a[15:8]);
            host.ser(a[7:0]);
        end
    endtask
    task write_enable_command;
        begin
            host.frame_on;
            host.ser(8'h06);
            host.frame_off;
        end
    endtask
    // bounded wait for the timed cycle to end
    task settle;
        begin
            for (j = 0; j < 1000 && write_in_progress !== 1'b0; j = j + 1)
                @(negedge clk_in);
        end
    endtask
    // an unsent byte holds no defined data, only its flag counts
    task buf_chk(input [7:0] a, input [8:0] e);
        begin
            baddr = a;
            repeat (2) @(negedge clk_in);
            check({bmask, bmask ? bdata : 8'h00}, e);
        end
    endtask
    // word read: any address, mode byte, two dummies
    task qread(input [23:0] a, input [7:0] m, input op);
        integer k;
        begin
            host.frame_on;
            if (op) host.ser(8'he7);
            for (k = 5; k >= 0; k = k - 1)
                host.clk1(a[4*k+3 -: 4], 4'hf, q);
            host.clk1(m[7:4], 4'hf, q);
            host.clk1(m[3:0], 4'hf, q);
            repeat (2) host.clk1(4'h0, 4'h0, q);
        end
    endtask
    task rdb;
        begin
            host.clk1(4'h0, 4'h0, q);
            host.clk1(4'h0, 4'h0, q2);
            bt = {q, q2};
        end
    endtask

    initial begin
        repeat (3) @(negedge clk_in);
        rst_n_in = 1'b1;
        repeat (8) @(negedge clk_in);
        wr(8'h02, 24'h001234);
        host.ser(8'h11);
        host.frame_off;
        check(starts, 0);
        write_enable_command;
        check(write_enable_latch, 1);
        wr(8'h02, 24'h0012fe);
        host.ser(8'hd0);
        host.ser(8'hd1);
        host.ser(8'hd2);
        host.frame_off;
        check(op_addr, 24'h001200);
        check({starts[3:0], write_in_progress, write_enable_latch}, 6'h06);
        settle;
        check(wip_len > 38 && wip_len < 43, 1);
        buf_chk(8'hfe, 9'h1d0);
        buf_chk(8'h00, 9'h1d2);
        buf_chk(8'h01, 9'h000);
        write_enable_command;
        wr(8'h02, 24'h001300);
        host.ser(8'h55);
        repeat (4) host.clk1(4'h1, 4'h1, q);
        host.frame_off;
        check({starts[3:0], write_enable_latch}, 5'h03);
        prot = 1'b1;
        wr(8'h20, 24'h123456);
        host.frame_off;
        prot = 1'b0;
        check(starts, 1);
        check({pk, pa}, 26'h1123456);
        wr(8'h20, 24'h123456);
        host.clk1(4'h0, 4'h1, q);
        host.frame_off;
        check(starts, 1);
        wr(8'h20, 24'h123456);
        host.frame_off;
        check({kind, op_addr[23:12]}, 14'h1123);
        host.frame_on;
        host.ser(8'h05);
        for (j = 0; j < 8; j = j + 1) begin
            host.clk1(4'h0, 4'h0, q);
            bt = {bt[6:0], q[1]};
        end
        host.frame_off;
        check(bt, 8'h01);
        settle;
        check(wip_len > 398 && wip_len < 403, 1);
        write_enable_command;
        prot = 1'b1;
        wr(8'h52, 24'h018000);
        host.frame_off;
        prot = 1'b0;
        check(starts, 2);
        check({pk, pa}, 26'h2018000);
        wr(8'h52, 24'h018000);
        host.frame_off;
        check(kind, 2);
        settle;
        check(wip_len > 78 && wip_len < 83, 1);
        qread(24'h000134, 8'ha5, 1'b1);
        rdb;
        check(bt, 8'h34 ^ 8'ha5);
        rdb;
        check(bt, 8'h35 ^ 8'ha5);
        host.frame_off;
        check(cont, 1);
        qread(24'h000256, 8'h00, 1'b0);
        rdb;
        check(bt, 8'h56 ^ 8'ha5);
        host.frame_off;
        check(cont, 0);
        qread(24'h000100, 8'ha0, 1'b1);
        host.frame_off;
        host.frame_on;
        repeat (8) host.clk1(4'hf, 4'hf, q);
        host.frame_off;
        check(cont, 0);
        qe = 1'b0;
        qread(24'h000100, 8'ha0, 1'b1);
        host.frame_off;
        check(cont, 0);
        complete_run;
    end

    // watchdog: the run needs well under a millisecond
    initial begin
        #1500000;
        n_fail = n_fail + 1;
        complete_run;
    end
endmodule // tb_qw_flash_seq
